//--- design/abcr_pkg.sv
// constants, field layout and carrier types of the pair b control bank
package abcr_pkg;
  // register addresses
  localparam logic [6:0] ADDR_MODE_ONE = 7'h0d;
  localparam logic [6:0] ADDR_MODE_TWO = 7'h0e;
  localparam logic [6:0] ADDR_POWER = 7'h10;
  localparam logic [6:0] ADDR_INPUT_SEL = 7'h12;
  localparam logic [6:0] ADDR_MIC_GAIN = 7'h13;
  localparam logic [6:0] ADDR_OUT_FORMAT = 7'h14;
  localparam logic [6:0] ADDR_FILTER_SEL = 7'h15;
  localparam logic [6:0] ADDR_INIT_LEN = 7'h16;
  localparam logic [6:0] ADDR_VOL_MODE = 7'h17;
  localparam logic [6:0] ADDR_LEFT_VOL = 7'h18;
  localparam logic [6:0] ADDR_RIGHT_VOL = 7'h19;
  localparam logic [6:0] ADDR_TIMERS = 7'h1a;
  localparam logic [6:0] ADDR_RECOV_REF = 7'h1b;
  localparam logic [6:0] ADDR_LEVEL_CTRL = 7'h1c;
  localparam int REG_COUNT = 32;
  // reset values
  localparam logic [7:0] RST_MODE_ONE = 8'h00_a0;
  localparam logic [7:0] RST_MIC_GAIN = 8'h00_01;
  localparam logic [7:0] RST_OUT_FORMAT = 8'h00_20;
  localparam logic [7:0] RST_VOL_MODE = 8'h00_01;
  localparam logic [7:0] RST_VOLUME = 8'h00_91;
  localparam logic [7:0] RST_RECOV_REF = 8'h00_e1;
  // writable bits of each register
  localparam logic [7:0] WM_MODE_ONE = 8'h00_f3;
  localparam logic [7:0] WM_MODE_TWO = 8'h00_02;
  localparam logic [7:0] WM_POWER = 8'h00_03;
  localparam logic [7:0] WM_INPUT_SEL = 8'h00_7f;
  localparam logic [7:0] WM_MIC_GAIN = 8'h00_03;
  localparam logic [7:0] WM_OUT_FORMAT = 8'h00_10;
  localparam logic [7:0] WM_FILTER_SEL = 8'h00_c0;
  localparam logic [7:0] WM_INIT_LEN = 8'h00_80;
  localparam logic [7:0] WM_VOL_MODE = 8'h00_01;
  localparam logic [7:0] WM_FULL = 8'h00_ff;
  localparam logic [7:0] WM_TIMERS = 8'h00_7f;
  // unlock key patterns
  localparam logic [3:0] KEY_UNLOCK = 4'h5;
  localparam logic [3:0] KEY_LOCKED = 4'ha;
  // field positions
  localparam int POS_LINK = 0;
  localparam int POS_LIMIT_IMM = 1;
  localparam int POS_KEY = 4;
  localparam int POS_EXT_MASTER = 1;
  localparam int POS_SRC_L = 0;
  localparam int POS_SRC_R = 1;
  localparam int POS_TYPE_L = 2;
  localparam int POS_TYPE_R = 3;
  localparam int POS_BIAS = 4;
  localparam int POS_FIFTH_L = 5;
  localparam int POS_FIFTH_R = 6;
  localparam int POS_MIX = 4;
  localparam int POS_HPF = 6;
  localparam int POS_SHORT_INIT = 7;
  localparam int POS_VOL_DEP = 0;
  localparam int POS_WAIT_LO = 0;
  localparam int POS_ZC = 2;
  localparam int POS_WAIT_HI = 4;
  localparam int POS_RFST = 5;
  localparam int POS_LMTH = 0;
  localparam int POS_RG = 2;
  localparam int POS_LMAT = 4;
  localparam int POS_ZC_OFF = 6;
  localparam int POS_ALC_EN = 7;
  // initialization lengths, in sample periods
  localparam logic [11:0] INIT_LONG = 12'h0_c10;
  localparam logic [11:0] INIT_SHORT = 12'h0_610;
  localparam logic [1:0] HPF_SHORT_OK = 2'h3;
  // zero-crossing timeouts per code, in sample periods
  localparam logic [10:0] ZC_TMO_0 = 11'h0_80;
  localparam logic [10:0] ZC_TMO_1 = 11'h1_00;
  localparam logic [10:0] ZC_TMO_2 = 11'h2_00;
  localparam logic [10:0] ZC_TMO_3 = 11'h4_00;
  // serial control frame
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam int SAMPLE_W = 16;

  // serial frame states
  typedef enum logic [3:0] {
    SER_IDLE = 4'b0001,
    SER_CMD = 4'b0010,
    SER_DATA = 4'b0100,
    SER_DONE = 4'b1000
  } abcr_ser_e;

  // analog front-end controls
  typedef struct packed {
    logic [1:0] power;
    logic [1:0] source;
    logic [1:0] fifth_input;
    logic [1:0] input_type;
    logic bias_power;
    logic [1:0] amp_gain;
    logic [1:0] highpass_select;
  } abcr_analog_s;

  // level control settings
  typedef struct packed {
    logic four_loop_link_enable;
    logic limiter_immediate_select;
    logic loop_enable;
    logic limiter_zero_cross_off;
    logic [1:0] limiter_atten_step;
    logic [1:0] recovery_gain_step;
    logic [1:0] limiter_threshold;
    logic [2:0] recovery_wait;
    logic [1:0] first_recovery_speed;
    logic [7:0] recovery_reference;
  } abcr_alc_s;

  // whole module state
  typedef struct packed {
    logic [2:0] csn_sy;
    logic [2:0] clk_sy;
    logic [2:0] dat_sy;
    logic csn_f;
    logic clk_f;
    logic dat_f;
    abcr_ser_e ser;
    logic [4:0] bit_cnt;
    logic [15:0] shift_in;
    logic [7:0] shift_out;
    logic cdto;
    logic cdto_oe;
    logic [REG_COUNT-1:0][7:0] regs;
    logic [1:0] pwr_prev;
    logic [11:0] init_cnt;
    logic ready;
    logic [1:0][7:0] eff_vol;
    logic [1:0][10:0] zc_tmr;
    logic [1:0] sign_prev;
    logic [SAMPLE_W-1:0] out_l;
    logic [SAMPLE_W-1:0] out_r;
    logic out_valid;
  } abcr_state_s;
endpackage : abcr_pkg

//--- design/abcr_regs.sv
// pair b control register bank with serial port, init and volume timing
// Functional notes
// - link bit joins all four level loops
// - limiter select: zero-cross or immediate attenuation
// - mode two writable only with key 0101
// - external master bit gated by unlock key
// - frame clock driven once external master set, only while TDM_MASTER is high
// - per-side power bits, default powered down
// - power rise runs init, data after
// - source bits pick third or fourth input
// - fifth-input bits override third/fourth choice
// - type bits pick single-ended or differential
// - bias pin high-impedance until bias powered
// - amp gain field resets to 01
// - mix bit outputs (L+R)/2 on both
// - filter field defaults 00, long init
// - short-init bit counts only with filter 11
// - dependent mode: left volume drives both
// - volume registers reset to 91h
// - recovery wait field, default code zero
// - volume changes at zero cross or timeout
// - recovery speed 00, reference E1h default
// - level control fields all reset zero
// - reset pin low restores every default
`timescale 1ns/1ps
module abcr_regs
  import abcr_pkg::*;
(
  // clock and power-down reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // serial control port pins
  input wire logic CSN_B,
  input wire logic CCLK,
  input wire logic CDTI,
  output logic CDTO,
  output logic CDTO_OE,
  // sample stream, one pulse per sample period
  input wire logic FS_TICK,
  input wire logic [SAMPLE_W-1:0] SAMPLE_L,
  input wire logic [SAMPLE_W-1:0] SAMPLE_R,
  output logic [SAMPLE_W-1:0] OUT_L,
  output logic [SAMPLE_W-1:0] OUT_R,
  output logic OUT_VALID,
  // clocking
  input wire logic TDM_MASTER,
  output logic EXT_MASTER_MODE,
  output logic FRAME_CLOCK_OE,
  // front end and level control
  output abcr_analog_s ANALOG_CTRL,
  output logic BIAS_PIN_OE,
  output logic [7:0] VOLUME_L,
  output logic [7:0] VOLUME_R,
  output abcr_alc_s ALC_CTRL
);

  // reset value of each address; unmapped ones read zero
  function automatic logic [7:0] reg_reset(input logic [6:0] a);
    unique case (a)
      ADDR_MODE_ONE: reg_reset = RST_MODE_ONE;
      ADDR_MIC_GAIN: reg_reset = RST_MIC_GAIN;
      ADDR_OUT_FORMAT: reg_reset = RST_OUT_FORMAT;
      ADDR_VOL_MODE: reg_reset = RST_VOL_MODE;
      ADDR_LEFT_VOL, ADDR_RIGHT_VOL: reg_reset = RST_VOLUME;
      ADDR_RECOV_REF: reg_reset = RST_RECOV_REF;
      default: reg_reset = 8'h00_00;
    endcase
  endfunction : reg_reset

  // writable bits; zero mask marks an unmapped address
  function automatic logic [7:0] reg_wmask(input logic [6:0] a);
    unique case (a)
      ADDR_MODE_ONE: reg_wmask = WM_MODE_ONE;
      ADDR_MODE_TWO: reg_wmask = WM_MODE_TWO;
      ADDR_POWER: reg_wmask = WM_POWER;
      ADDR_INPUT_SEL: reg_wmask = WM_INPUT_SEL;
      ADDR_MIC_GAIN: reg_wmask = WM_MIC_GAIN;
      ADDR_OUT_FORMAT: reg_wmask = WM_OUT_FORMAT;
      ADDR_FILTER_SEL: reg_wmask = WM_FILTER_SEL;
      ADDR_INIT_LEN: reg_wmask = WM_INIT_LEN;
      ADDR_VOL_MODE: reg_wmask = WM_VOL_MODE;
      ADDR_LEFT_VOL, ADDR_RIGHT_VOL: reg_wmask = WM_FULL;
      ADDR_TIMERS: reg_wmask = WM_TIMERS;
      ADDR_RECOV_REF, ADDR_LEVEL_CTRL: reg_wmask = WM_FULL;
      default: reg_wmask = 8'h00_00;
    endcase
  endfunction : reg_wmask

  // timeout length for a zero-crossing code
  function automatic logic [10:0] zc_limit(input logic [1:0] code);
    unique case (code)
      2'h0: zc_limit = ZC_TMO_0;
      2'h1: zc_limit = ZC_TMO_1;
      2'h2: zc_limit = ZC_TMO_2;
      default: zc_limit = ZC_TMO_3;
    endcase
  endfunction : zc_limit

  abcr_state_s st_r;
  abcr_state_s st_nxt;

  // decoded views of the register file
  logic [7:0] r_mode1, r_mode2, r_pwr, r_sel, r_fmt, r_flt, r_inc;
  logic [7:0] r_vol_l, r_vol_r, r_tmr, r_lvl;
  logic [3:0] key;
  logic [1:0] pwr, pwr_rise;
  logic [11:0] init_len;
  logic vol_dep, mix;
  logic [1:0][7:0] vol_target;
  logic [10:0] zc_tmo;
  logic clk_rise, clk_fall;
  logic [6:0] cmd_addr;
  logic wr_fire;
  logic [7:0] wr_data;
  logic [SAMPLE_W:0] sum;

  assign r_mode1 = st_r.regs[ADDR_MODE_ONE[4:0]];
  assign r_mode2 = st_r.regs[ADDR_MODE_TWO[4:0]];
  assign r_pwr = st_r.regs[ADDR_POWER[4:0]];
  assign r_sel = st_r.regs[ADDR_INPUT_SEL[4:0]];
  assign r_fmt = st_r.regs[ADDR_OUT_FORMAT[4:0]];
  assign r_flt = st_r.regs[ADDR_FILTER_SEL[4:0]];
  assign r_inc = st_r.regs[ADDR_INIT_LEN[4:0]];
  assign r_vol_l = st_r.regs[ADDR_LEFT_VOL[4:0]];
  assign r_vol_r = st_r.regs[ADDR_RIGHT_VOL[4:0]];
  assign r_tmr = st_r.regs[ADDR_TIMERS[4:0]];
  assign r_lvl = st_r.regs[ADDR_LEVEL_CTRL[4:0]];
  assign key = r_mode1[POS_KEY+:4];
  assign pwr = r_pwr[1:0];
  assign pwr_rise = pwr & ~st_r.pwr_prev;
  assign vol_dep = st_r.regs[ADDR_VOL_MODE[4:0]][POS_VOL_DEP];
  assign mix = r_fmt[POS_MIX];
  assign zc_tmo = zc_limit(r_tmr[POS_ZC+:2]);

  // short init only honoured with filter code 11
  assign init_len = (r_flt[POS_HPF+:2] == HPF_SHORT_OK && r_inc[POS_SHORT_INIT])
                    ? INIT_SHORT : INIT_LONG;

  // dependent mode reuses the left value without copying it across
  assign vol_target[0] = r_vol_l;
  assign vol_target[1] = vol_dep ? r_vol_l : r_vol_r;

  // edges are taken from the filtered pins, never from the first stage;
  // they read only registered stages so the next-state logic has no loop
  assign clk_rise = !st_r.clk_f && st_r.clk_sy[1] && st_r.clk_sy[2];
  assign clk_fall = st_r.clk_f && !st_r.clk_sy[1] && !st_r.clk_sy[2];
  // address sits below the write flag once the data byte is in
  assign cmd_addr = st_r.shift_in[13:7];
  assign wr_data = {st_r.shift_in[6:0], st_r.dat_f};
  assign wr_fire = st_r.ser == SER_DATA && clk_rise && !st_r.csn_f &&
                   st_r.bit_cnt == FRAME_BITS - 5'h01 &&
                   st_r.shift_in[14];
  assign sum = {SAMPLE_L[SAMPLE_W-1], SAMPLE_L} +
               {SAMPLE_R[SAMPLE_W-1], SAMPLE_R};

  // next-state logic for the whole block
  always_comb begin
    logic [6:0] wa;
    wa = cmd_addr;
    st_nxt = st_r;
    // three-stage pin capture; a change counts once stages two and three agree
    st_nxt.csn_sy = {st_r.csn_sy[1:0], CSN_B};
    st_nxt.clk_sy = {st_r.clk_sy[1:0], CCLK};
    st_nxt.dat_sy = {st_r.dat_sy[1:0], CDTI};
    if (st_r.csn_sy[1] == st_r.csn_sy[2]) begin
      st_nxt.csn_f = st_r.csn_sy[2];
    end
    if (st_r.clk_sy[1] == st_r.clk_sy[2]) begin
      st_nxt.clk_f = st_r.clk_sy[2];
    end
    if (st_r.dat_sy[1] == st_r.dat_sy[2]) begin
      st_nxt.dat_f = st_r.dat_sy[2];
    end
    // serial frame: command byte then data byte, msb first
    if (st_nxt.csn_f) begin
      st_nxt.ser = SER_IDLE;
      st_nxt.bit_cnt = 5'h00;
      st_nxt.cdto_oe = 1'b0;
    end else begin
      unique case (st_r.ser)
        SER_IDLE: begin
          st_nxt.ser = SER_CMD;
        end
        SER_CMD: begin
          if (clk_rise) begin
            st_nxt.shift_in = {st_r.shift_in[14:0], st_r.dat_f};
            st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
            if (st_r.bit_cnt == CMD_BITS - 5'h01) begin
              st_nxt.ser = SER_DATA;
              // reads of unmapped addresses return zero
              st_nxt.shift_out = (reg_wmask(wr_data[6:0]) != 8'h00_00)
                                 ? st_r.regs[wr_data[4:0]] : 8'h00_00;
              st_nxt.cdto_oe = ~st_r.shift_in[6];
            end
          end
        end
        SER_DATA: begin
          if (clk_fall && st_r.cdto_oe) begin
            st_nxt.cdto = st_r.shift_out[7];
            st_nxt.shift_out = {st_r.shift_out[6:0], 1'b0};
          end
          if (clk_rise) begin
            st_nxt.shift_in = {st_r.shift_in[14:0], st_r.dat_f};
            st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
            if (st_r.bit_cnt == FRAME_BITS - 5'h01) begin
              st_nxt.ser = SER_DONE;
            end
          end
        end
        SER_DONE: begin
          // extra clocks are ignored until the select rises
          st_nxt.cdto_oe = 1'b0;
        end
      endcase
    end
    // masked write; fixed bits keep their constant value, and an unmapped
    // address must not alias onto a mapped one through its low five bits
    if (wr_fire && reg_wmask(wa) != 8'h00_00 &&
        !(wa == ADDR_MODE_TWO && key != KEY_UNLOCK)) begin
      st_nxt.regs[wa[4:0]] = (wr_data & reg_wmask(wa)) |
                             (reg_reset(wa) & ~reg_wmask(wa));
    end
    // init cycle restarts on any power bit rise
    st_nxt.pwr_prev = pwr;
    if (pwr_rise != 2'b00) begin
      st_nxt.init_cnt = init_len;
      st_nxt.ready = 1'b0;
    end else if (pwr == 2'b00) begin
      st_nxt.ready = 1'b0;
    end else if (FS_TICK && st_r.init_cnt != 12'h0_000) begin
      st_nxt.init_cnt = st_r.init_cnt - 12'h0_001;
    end else if (st_r.init_cnt == 12'h0_000) begin
      st_nxt.ready = 1'b1;
    end
    // volume follows its target at a zero crossing or at the timeout
    for (int s = 0; s < 2; s++) begin
      if (FS_TICK) begin
        st_nxt.sign_prev[s] = (s == 0) ? SAMPLE_L[SAMPLE_W-1]
                                       : SAMPLE_R[SAMPLE_W-1];
        if (st_r.eff_vol[s] != vol_target[s]) begin
          if (st_nxt.sign_prev[s] != st_r.sign_prev[s] ||
              st_r.zc_tmr[s] + 11'h001 >= zc_tmo) begin
            st_nxt.eff_vol[s] = vol_target[s];
            st_nxt.zc_tmr[s] = 11'h000;
          end else begin
            st_nxt.zc_tmr[s] = st_r.zc_tmr[s] + 11'h001;
          end
        end else begin
          st_nxt.zc_tmr[s] = 11'h000;
        end
      end
    end
    // output data; mixing trades stereo for a single averaged channel
    st_nxt.out_valid = FS_TICK && st_r.ready;
    if (FS_TICK && st_r.ready) begin
      st_nxt.out_l = mix ? sum[SAMPLE_W:1] : SAMPLE_L;
      st_nxt.out_r = mix ? sum[SAMPLE_W:1] : SAMPLE_R;
    end
  end

  // state register; the reset pin restores every default
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      st_r <= '0;
      st_r.ser <= SER_IDLE;
      st_r.csn_sy <= 3'h7;
      st_r.csn_f <= 1'b1;
      // serial clock idles high; a low reset value would fake a rise
      st_r.clk_sy <= 3'h7;
      st_r.clk_f <= 1'b1;
      for (int a = 0; a < REG_COUNT; a++) begin
        st_r.regs[a] <= reg_reset(7'(a));
      end
      st_r.eff_vol <= {RST_VOLUME, RST_VOLUME};
    end else begin
      st_r <= st_nxt;
    end
  end

  // pins and controls
  assign CDTO = st_r.cdto;
  assign CDTO_OE = st_r.cdto_oe;
  assign OUT_L = st_r.out_l;
  assign OUT_R = st_r.out_r;
  assign OUT_VALID = st_r.out_valid;
  assign EXT_MASTER_MODE = r_mode2[POS_EXT_MASTER];
  assign FRAME_CLOCK_OE = TDM_MASTER & r_mode2[POS_EXT_MASTER];
  assign BIAS_PIN_OE = r_sel[POS_BIAS];
  assign VOLUME_L = st_r.eff_vol[0];
  assign VOLUME_R = st_r.eff_vol[1];

  // front-end selections straight from the registers
  assign ANALOG_CTRL.power = pwr;
  assign ANALOG_CTRL.source = {r_sel[POS_SRC_R], r_sel[POS_SRC_L]};
  assign ANALOG_CTRL.fifth_input = {r_sel[POS_FIFTH_R],
                                    r_sel[POS_FIFTH_L]};
  assign ANALOG_CTRL.input_type = {r_sel[POS_TYPE_R],
                                   r_sel[POS_TYPE_L]};
  assign ANALOG_CTRL.bias_power = r_sel[POS_BIAS];
  assign ANALOG_CTRL.amp_gain =
    st_r.regs[ADDR_MIC_GAIN[4:0]][1:0];
  assign ANALOG_CTRL.highpass_select = r_flt[POS_HPF+:2];

  // level-loop settings
  assign ALC_CTRL.four_loop_link_enable = r_mode1[POS_LINK];
  assign ALC_CTRL.limiter_immediate_select = r_mode1[POS_LIMIT_IMM];
  assign ALC_CTRL.loop_enable = r_lvl[POS_ALC_EN];
  assign ALC_CTRL.limiter_zero_cross_off = r_lvl[POS_ZC_OFF];
  assign ALC_CTRL.limiter_atten_step = r_lvl[POS_LMAT+:2];
  assign ALC_CTRL.recovery_gain_step = r_lvl[POS_RG+:2];
  assign ALC_CTRL.limiter_threshold = r_lvl[POS_LMTH+:2];
  assign ALC_CTRL.recovery_wait = {r_tmr[POS_WAIT_HI],
                                   r_tmr[POS_WAIT_LO+:2]};
  assign ALC_CTRL.first_recovery_speed = r_tmr[POS_RFST+:2];
  assign ALC_CTRL.recovery_reference =
    st_r.regs[ADDR_RECOV_REF[4:0]];

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  property p_key_lock;
    wr_fire && cmd_addr == ADDR_MODE_TWO && key != KEY_UNLOCK
      |=> $stable(EXT_MASTER_MODE);
  endproperty
  a_key_lock: assert property (p_key_lock) else $error("locked write took");
  property p_key_open;
    wr_fire && cmd_addr == ADDR_MODE_TWO && key == KEY_UNLOCK
      |=> EXT_MASTER_MODE == $past(wr_data[POS_EXT_MASTER]);
  endproperty
  a_key_open: assert property (p_key_open) else $error("unlocked write lost");
  property p_frame_clk;
    $rose(EXT_MASTER_MODE) && TDM_MASTER |-> FRAME_CLOCK_OE;
  endproperty
  a_frame_clk: assert property (p_frame_clk) else $error("frame clock off");
  property p_init_len;
    pwr_rise != 2'b00 |=> st_r.init_cnt == $past(init_len) && !st_r.ready;
  endproperty
  a_init_len: assert property (p_init_len) else $error("bad init length");
  property p_no_early_data;
    st_r.init_cnt != 12'h0_000 |-> ##1 !OUT_VALID;
  endproperty
  a_no_early_data: assert property (p_no_early_data) else $error("early data");
  property p_mix;
    FS_TICK && st_r.ready && mix |=> OUT_VALID && OUT_L == OUT_R;
  endproperty
  a_mix: assert property (p_mix) else $error("mix not averaged");
  property p_defaults;
    $past(!RST_B) |-> r_vol_l == RST_VOLUME && r_lvl == 8'h00_00 &&
      st_r.regs[ADDR_RECOV_REF[4:0]] == RST_RECOV_REF && key == KEY_LOCKED;
  endproperty
  a_defaults: assert property (p_defaults) else $error("bad default");
  property p_timeout;
    st_r.zc_tmr[0] < zc_tmo && st_r.zc_tmr[1] < zc_tmo;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout overrun");
  property p_dep_vol;
    $changed(VOLUME_R) && vol_dep |-> VOLUME_R == r_vol_l;
  endproperty
  a_dep_vol: assert property (p_dep_vol) else $error("right not from left");
  property p_fixed;
    st_r.regs[ADDR_OUT_FORMAT[4:0]][5] && r_mode2[7:2] == 6'h00;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bit changed");
  property p_vol_hold;
    !FS_TICK |=> $stable(VOLUME_L) && $stable(VOLUME_R);
  endproperty
  a_vol_hold: assert property (p_vol_hold) else $error("vol moved");
  property p_power_off;
    pwr == 2'b00 |=> !st_r.ready;
  endproperty
  a_power_off: assert property (p_power_off) else $error("not powered");

  c_unlock: cover property (wr_fire ##1 $rose(EXT_MASTER_MODE));
  c_init_done: cover property ($rose(st_r.ready));
  c_mix_out: cover property (OUT_VALID && mix);
  c_zc_update: cover property ($changed(VOLUME_L));

endmodule : abcr_regs

//--- test/abcr_host.sv
// host-side serial control master model for the pair b bank
`timescale 1ns/1ps
module abcr_host (
  // system clock that paces the serial pins
  input wire logic CLOCK,
  // serial control pins
  output logic CSN_B,
  output logic CCLK,
  output logic CDTI,
  input wire logic CDTO,
  input wire logic CDTO_OE
);
  // clock cycles per serial level, kept well above the 4-cycle floor
  localparam int HALF = 8;
  // serial clock idles high and stands still between frames
  initial begin
    CSN_B = 1'b1;
    CCLK = 1'b1;
    CDTI = 1'b0;
  end
  // wait n edges, then step just off the edge
  task automatic hold(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : hold
  // one frame: write flag, 7-bit address, 8-bit data, msb first
  task automatic xfer(input logic wr, input logic [6:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {wr, addr, wdata};
    rdata = 8'h00;
    hold(1);
    CSN_B = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      hold(HALF);
      CCLK = 1'b0;
      CDTI = frame[i];
      hold(HALF);
      // undriven read data must not pass as a bit
      if (i < 8) rdata[i] = CDTO_OE ? CDTO : 1'bx;
      CCLK = 1'b1;
    end
    hold(HALF);
    CSN_B = 1'b1;
    // released line has no pull, so it must not keep the last bit
    CDTI = ~CDTI;
    hold(HALF);
  endtask : xfer
endmodule : abcr_host

//--- test/abcr_regs_bench.sv
// self-checking bench for the pair b control register bank
`timescale 1ns/1ps
module abcr_regs_bench;
  import abcr_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic fs_tick = 1'b0;
  logic tdm_master = 1'b0;
  logic [SAMPLE_W-1:0] sample_l = '0;
  logic [SAMPLE_W-1:0] sample_r = '0;
  logic csn_b, cclk, cdti, cdto, cdto_oe, out_valid;
  logic [SAMPLE_W-1:0] out_l, out_r;
  logic ext_master_mode, frame_clock_oe, bias_pin_oe;
  logic [7:0] volume_l, volume_r, rd;
  abcr_analog_s analog_ctrl;
  abcr_alc_s alc_ctrl;
  int failures = 0;
  int n_checks = 0;
  int first;
  // address, reset value, readback after writing all ones
  logic [6:0] t_addr [15] = '{7'h0d, 7'h0e, 7'h10, 7'h12, 7'h13, 7'h14,
    7'h15, 7'h16, 7'h17, 7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h1f};
  logic [7:0] t_rst [15] = '{8'ha0, 8'h00, 8'h00, 8'h00, 8'h01, 8'h20,
    8'h00, 8'h00, 8'h01, 8'h91, 8'h91, 8'h00, 8'he1, 8'h00, 8'h00};
  logic [7:0] t_ones [15] = '{8'ha0, 8'h00, 8'h03, 8'h7f, 8'h03, 8'h30,
    8'hc0, 8'h80, 8'h01, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h00};

  // 100 MHz clock
  always #5 clock = ~clock;

  abcr_host host (.CLOCK(clock), .CSN_B(csn_b), .CCLK(cclk), .CDTI(cdti),
    .CDTO(cdto), .CDTO_OE(cdto_oe));

  abcr_regs dut (.CLOCK(clock), .RST_B(rst_b), .CSN_B(csn_b), .CCLK(cclk),
    .CDTI(cdti), .CDTO(cdto), .CDTO_OE(cdto_oe), .FS_TICK(fs_tick),
    .SAMPLE_L(sample_l), .SAMPLE_R(sample_r), .OUT_L(out_l),
    .OUT_R(out_r), .OUT_VALID(out_valid), .TDM_MASTER(tdm_master),
    .EXT_MASTER_MODE(ext_master_mode), .FRAME_CLOCK_OE(frame_clock_oe),
    .ANALOG_CTRL(analog_ctrl), .BIAS_PIN_OE(bias_pin_oe),
    .VOLUME_L(volume_l), .VOLUME_R(volume_r), .ALC_CTRL(alc_ctrl));

  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask : wr

  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    host.xfer(1'b0, a, 8'h00, rd);
    chk($sformatf("reg %h", a), 32'(exp), 32'(rd));
  endtask : rdc

  // one sample period; output is settled when this returns
  task automatic tick(input logic [15:0] l, input logic [15:0] r);
    @(posedge clock);
    #1;
    fs_tick = 1'b1;
    sample_l = l;
    sample_r = r;
    @(posedge clock);
    #1;
    fs_tick = 1'b0;
  endtask : tick

  // returns the index of the first tick with output data, 0 if none
  task automatic run_ticks(input int n, output int f);
    f = 0;
    for (int i = 1; i <= n; i++) begin
      tick(16'h0064, 16'h012c);
      if (out_valid === 1'b1 && f == 0) f = i;
    end
  endtask : run_ticks

  task automatic do_reset;
    @(posedge clock);
    #1;
    rst_b = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge clock);
    #1;
  endtask : do_reset

  task automatic t_defaults;
    for (int i = 0; i < 15; i++) begin
      rdc(t_addr[i], t_rst[i]);
    end
    chk("volume_l", 32'h91, 32'(volume_l));
    chk("volume_r", 32'h91, 32'(volume_r));
    chk("bias_oe", 32'h0, 32'(bias_pin_oe));
  endtask : t_defaults

  // all-ones write to every register but mode one keeps its fixed bits; locked mode two stays clear
  task automatic t_fixed_bits;
    for (int i = 1; i < 15; i++) begin
      wr(t_addr[i], 8'hff);
      rdc(t_addr[i], t_ones[i]);
      wr(t_addr[i], t_rst[i]);
    end
  endtask : t_fixed_bits

  task automatic t_key;
    wr(7'h0d, 8'h53);
    chk("link", 32'h1, 32'(alc_ctrl.four_loop_link_enable));
    chk("imm", 32'h1, 32'(alc_ctrl.limiter_immediate_select));
    tdm_master = 1'b1;
    #1;
    chk("frame_oe", 32'h0, 32'(frame_clock_oe));
    wr(7'h0e, 8'hff);
    rdc(7'h0e, 8'h02);
    chk("ext", 32'h1, 32'(ext_master_mode));
    chk("frame_oe", 32'h1, 32'(frame_clock_oe));
    tdm_master = 1'b0;
    #1;
    chk("frame_oe", 32'h0, 32'(frame_clock_oe));
    wr(7'h0d, 8'ha0);
    wr(7'h0e, 8'h00);
    rdc(7'h0e, 8'h02);
    chk("link", 32'h0, 32'(alc_ctrl.four_loop_link_enable));
    wr(7'h0d, 8'h50);
    wr(7'h0e, 8'h00);
    chk("ext", 32'h0, 32'(ext_master_mode));
    wr(7'h0d, 8'ha0);
  endtask : t_key

  task automatic t_fields;
    wr(7'h12, 8'h55);
    wr(7'h13, 8'h02);
    chk("analog", 32'(13'b00_01_10_01_1_10_00), 32'(analog_ctrl));
    chk("bias_oe", 32'h1, 32'(bias_pin_oe));
    wr(7'h12, 8'h2a);
    chk("analog", 32'(13'b00_10_01_10_0_10_00), 32'(analog_ctrl));
    chk("bias_oe", 32'h0, 32'(bias_pin_oe));
    wr(7'h1a, 8'h6b);
    wr(7'h1b, 8'h5a);
    wr(7'h1c, 8'ha5);
    chk("alc", 32'h0014_af5a, 32'(alc_ctrl));
    wr(7'h1c, 8'h5a);
    chk("alc", 32'h000b_4f5a, 32'(alc_ctrl));
    for (int i = 3; i < 15; i++) begin
      wr(t_addr[i], t_rst[i]);
    end
  endtask : t_fields

  // init length: long by default, short only with filter code 11
  task automatic t_init;
    wr(7'h10, 8'h01);
    chk("power", 32'h1, 32'(analog_ctrl.power));
    run_ticks(3095, first);
    chk("init", 32'h1, 32'(first > 3088 && first <= 3090));
    tick(16'h0064, 16'h012c);
    chk("out_l", 32'h64, 32'(out_l));
    chk("out_r", 32'h12c, 32'(out_r));
    wr(7'h14, 8'h30);
    tick(16'h0064, 16'h012c);
    chk("mix_l", 32'hc8, 32'(out_l));
    chk("mix_r", 32'hc8, 32'(out_r));
    wr(7'h14, 8'h20);
    wr(7'h10, 8'h00);
    tick(16'h0064, 16'h012c);
    chk("valid", 32'h0, 32'(out_valid));
    wr(7'h15, 8'hc0);
    chk("hpf", 32'h3, 32'(analog_ctrl.highpass_select));
    wr(7'h16, 8'h80);
    wr(7'h10, 8'h02);
    run_ticks(1560, first);
    chk("init", 32'h1, 32'(first > 1552 && first <= 1554));
    wr(7'h10, 8'h00);
    wr(7'h15, 8'h40);
    wr(7'h10, 8'h01);
    run_ticks(3095, first);
    chk("init", 32'h1, 32'(first > 3088 && first <= 3090));
    wr(7'h10, 8'h00);
    wr(7'h15, 8'h00);
    wr(7'h16, 8'h00);
  endtask : t_init

  task automatic t_volume;
    wr(7'h18, 8'h40);
    chk("volume_l", 32'h91, 32'(volume_l));
    run_ticks(130, first);
    chk("volume_l", 32'h40, 32'(volume_l));
    chk("volume_r", 32'h40, 32'(volume_r));
    rdc(7'h19, 8'h91);
    wr(7'h17, 8'h00);
    wr(7'h19, 8'h20);
    tick(16'h0064, 16'h012c);
    chk("volume_r", 32'h40, 32'(volume_r));
    tick(16'h0064, 16'hfffb);
    chk("volume_r", 32'h20, 32'(volume_r));
  endtask : t_volume

  // main sequence
  initial begin
    do_reset();
    t_defaults();
    t_fixed_bits();
    t_key();
    t_fields();
    t_init();
    t_volume();
    do_reset();
    t_defaults();
    tally_and_finish();
  end

  // hang guard, roughly twice the expected run
  initial begin
    repeat (90000) @(posedge clock);
    failures++;
    tally_and_finish();
  end
endmodule : abcr_regs_bench
